// ### accel_ctrl_pkg.sv
package accel_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SAMPLE_W = 16;

  localparam logic [7:0] ADDR_DRDY_STATUS = 8'h1D;
  localparam logic [7:0] ADDR_RANGE = 8'h41;
  localparam logic [7:0] ADDR_PIN1_CFG = 8'h53;
  localparam logic [7:0] ADDR_PIN2_CFG = 8'h54;
  localparam logic [7:0] ADDR_ROUTING = 8'h58;
  localparam logic [7:0] ADDR_SELFTEST = 8'h6D;
  localparam logic [7:0] ADDR_PWR_SAVE = 8'h7C;
  localparam logic [7:0] ADDR_PWR_EN = 8'h7D;
  localparam logic [7:0] ADDR_SOFTRESET = 8'h7E;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h81;

  localparam logic [7:0] RANGE_RST = 8'h01;
  localparam logic [7:0] RANGE_MASK = 8'h03;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_MASK = 8'h1E;
  localparam logic [7:0] ROUTING_RST = 8'h00;
  localparam logic [7:0] ROUTING_MASK = 8'h44;
  localparam logic [7:0] SELFTEST_RST = 8'h00;
  localparam logic [7:0] SELFTEST_POS = 8'h0D;
  localparam logic [7:0] PWR_SAVE_RST = 8'h03;
  localparam logic [7:0] PWR_SAVE_ACTIVE = 8'h00;
  localparam logic [7:0] PWR_EN_RST = 8'h00;
  localparam logic [7:0] PWR_EN_ON = 8'h04;
  localparam logic [7:0] SOFTRESET_KEY = 8'hB6;
  localparam logic [7:0] IRQ_RST = 8'h00;

  localparam int unsigned PIN_IN_BIT = 4;
  localparam int unsigned PIN_OUT_BIT = 3;
  localparam int unsigned PIN_OD_BIT = 2;
  localparam int unsigned PIN_LVL_BIT = 1;
  localparam int unsigned ROUTE_P2_BIT = 6;
  localparam int unsigned ROUTE_P1_BIT = 2;
  localparam int unsigned DRDY_BIT = 7;
  localparam int unsigned IRQ_DRDY_BIT = 0;
  localparam int unsigned IRQ_SRST_BIT = 1;

  localparam int unsigned CLOCK_HZ = 20000000;
  localparam int unsigned SOFTRESET_US = 1000;
  localparam int unsigned SOFTRESET_CYCLES =
    (SOFTRESET_US * (CLOCK_HZ / 1000000));

  typedef struct packed {
    logic input_en;
    logic output_en;
    logic drive_sel;
    logic polarity;
  } pin_cfg_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic in;
  } irq_pin_s;

  typedef enum logic [0:0] {
    SRST_IDLE = 1'b0,
    SRST_WAIT = 1'b1
  } srst_state_e;

endpackage

// ### accel_control_registers.sv
`timescale 1ns/1ps
module accel_control_registers #(
  parameter int unsigned SOFTRESET_CYCLES = accel_ctrl_pkg::SOFTRESET_CYCLES,
  parameter int unsigned SAMPLE_W         = accel_ctrl_pkg::SAMPLE_W,
  parameter logic [15:0] SELFTEST_OFFSET  = 16'h0400
) (
  input  wire logic                                clock,
  input  wire logic                                reset_n,
  input  wire logic [accel_ctrl_pkg::ADDR_W-1:0]   addr,
  input  wire logic [accel_ctrl_pkg::DATA_W-1:0]   wdata,
  input  wire logic                                wr_en,
  input  wire logic                                rd_en,
  output logic      [accel_ctrl_pkg::DATA_W-1:0]   rdata,
  input  wire logic                                sample_strobe,
  input  wire logic [SAMPLE_W-1:0]                 raw_sample,
  output logic                                     sample_valid,
  output logic      [SAMPLE_W-1:0]                 sample_out,
  output logic      [1:0]                          range_code,
  output logic                                     accel_active,
  output logic                                     selftest_on,
  input  wire logic                                irq_pin_one_in,
  output logic                                     irq_pin_one_out,
  output logic                                     irq_pin_one_oe,
  input  wire logic                                irq_pin_two_in,
  output logic                                     irq_pin_two_out,
  output logic                                     irq_pin_two_oe,
  output logic                                     pin_one_sense,
  output logic                                     pin_two_sense,
  output logic                                     irq
);

  //////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] accel_range_sel_reg;
  logic [7:0] pin1_io_config_reg;
  logic [7:0] pin2_io_config_reg;
  logic [7:0] drdy_pin_routing_reg;
  logic [7:0] selftest_control_reg;
  logic [7:0] power_save_config_reg;
  logic [7:0] sensor_power_enable_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic       drdy_reg;
  logic       soft_clear;
  logic       srst_done;

  accel_ctrl_pkg::srst_state_e srst_state_reg;
  logic [31:0]                 srst_count_reg;

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] r);
    is_wr = wr_en && (a == r);
  endfunction

  function automatic accel_ctrl_pkg::pin_cfg_s
    pin_cfg(input logic [7:0] v);
    pin_cfg.input_en  = v[accel_ctrl_pkg::PIN_IN_BIT];
    pin_cfg.output_en = v[accel_ctrl_pkg::PIN_OUT_BIT];
    pin_cfg.drive_sel = v[accel_ctrl_pkg::PIN_OD_BIT];
    pin_cfg.polarity  = v[accel_ctrl_pkg::PIN_LVL_BIT];
  endfunction

  // soft reset clears the bank except irq_mask_reg and irq_status_reg on the edge where the delay expires, SOFTRESET_CYCLES after the key write
  assign soft_clear = (srst_state_reg == accel_ctrl_pkg::SRST_WAIT) &&
                      (srst_count_reg == 32'h00000000);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      accel_range_sel_reg <= accel_ctrl_pkg::RANGE_RST;
    end else if (soft_clear) begin
      accel_range_sel_reg <= accel_ctrl_pkg::RANGE_RST;
    end else if (is_wr(addr, accel_ctrl_pkg::ADDR_RANGE)) begin
      accel_range_sel_reg <= wdata & accel_ctrl_pkg::RANGE_MASK;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin1_io_config_reg <= accel_ctrl_pkg::PIN_CFG_RST;
      pin2_io_config_reg <= accel_ctrl_pkg::PIN_CFG_RST;
    end else if (soft_clear) begin
      pin1_io_config_reg <= accel_ctrl_pkg::PIN_CFG_RST;
      pin2_io_config_reg <= accel_ctrl_pkg::PIN_CFG_RST;
    end else begin
      if (is_wr(addr, accel_ctrl_pkg::ADDR_PIN1_CFG)) begin
        pin1_io_config_reg <= wdata & accel_ctrl_pkg::PIN_CFG_MASK;
      end
      if (is_wr(addr, accel_ctrl_pkg::ADDR_PIN2_CFG)) begin
        pin2_io_config_reg <= wdata & accel_ctrl_pkg::PIN_CFG_MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drdy_pin_routing_reg <= accel_ctrl_pkg::ROUTING_RST;
    end else if (soft_clear) begin
      drdy_pin_routing_reg <= accel_ctrl_pkg::ROUTING_RST;
    end else if (is_wr(addr, accel_ctrl_pkg::ADDR_ROUTING)) begin
      drdy_pin_routing_reg <= wdata & accel_ctrl_pkg::ROUTING_MASK;
    end
  end

  // self-test stays on until software writes it off or a soft reset clears it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      selftest_control_reg <= accel_ctrl_pkg::SELFTEST_RST;
    end else if (soft_clear) begin
      selftest_control_reg <= accel_ctrl_pkg::SELFTEST_RST;
    end else if (is_wr(addr, accel_ctrl_pkg::ADDR_SELFTEST)) begin
      selftest_control_reg <= wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_save_config_reg   <= accel_ctrl_pkg::PWR_SAVE_RST;
      sensor_power_enable_reg <= accel_ctrl_pkg::PWR_EN_RST;
    end else if (soft_clear) begin
      power_save_config_reg   <= accel_ctrl_pkg::PWR_SAVE_RST;
      sensor_power_enable_reg <= accel_ctrl_pkg::PWR_EN_RST;
    end else begin
      if (is_wr(addr, accel_ctrl_pkg::ADDR_PWR_SAVE)) begin
        power_save_config_reg <= wdata;
      end
      if (is_wr(addr, accel_ctrl_pkg::ADDR_PWR_EN)) begin
        sensor_power_enable_reg <= wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // soft reset timer

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      srst_state_reg <= accel_ctrl_pkg::SRST_IDLE;
      srst_count_reg <= 32'h00000000;
    end else begin
      case (srst_state_reg)
        accel_ctrl_pkg::SRST_IDLE: begin
          if (is_wr(addr, accel_ctrl_pkg::ADDR_SOFTRESET) &&
              (wdata == accel_ctrl_pkg::SOFTRESET_KEY)) begin
            srst_state_reg <= accel_ctrl_pkg::SRST_WAIT;
            srst_count_reg <= SOFTRESET_CYCLES - 1;
          end
        end
        accel_ctrl_pkg::SRST_WAIT: begin
          if (srst_count_reg == 32'h00000000) begin
            srst_state_reg <= accel_ctrl_pkg::SRST_IDLE;
          end else begin
            srst_count_reg <= srst_count_reg - 32'h00000001;
          end
        end
        default: begin
          srst_state_reg <= accel_ctrl_pkg::SRST_IDLE;
        end
      endcase
    end
  end

  assign srst_done = soft_clear;

  //////////////////////////////////////////////////////////////////////////
  // acquisition

  // both controls must agree; host must power on after every reset
  assign accel_active =
    (power_save_config_reg == accel_ctrl_pkg::PWR_SAVE_ACTIVE) &&
    (sensor_power_enable_reg == accel_ctrl_pkg::PWR_EN_ON);
  assign selftest_on =
    (selftest_control_reg == accel_ctrl_pkg::SELFTEST_POS);
  assign range_code = accel_range_sel_reg[1:0];

  logic sample_take;
  assign sample_take = sample_strobe && accel_active;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sample_out   <= '0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= sample_take;
      if (sample_take) begin
        // wraps on overflow; offset is a fixed stimulus, not saturated
        sample_out <= selftest_on ?
          SAMPLE_W'(raw_sample + SAMPLE_W'(SELFTEST_OFFSET)) :
          raw_sample;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data-ready flag and interrupt status

  logic rd_drdy;
  logic rd_irq;
  assign rd_drdy = rd_en && (addr == accel_ctrl_pkg::ADDR_DRDY_STATUS);
  assign rd_irq  = rd_en && (addr == accel_ctrl_pkg::ADDR_IRQ_STATUS);

  // set wins over the read clear so no sample is lost
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drdy_reg <= 1'b0;
    end else if (sample_take) begin
      drdy_reg <= 1'b1;
    end else if (rd_drdy || soft_clear) begin
      drdy_reg <= 1'b0;
    end
  end

  logic [7:0] irq_events;
  always_comb begin
    irq_events = 8'h00;
    irq_events[accel_ctrl_pkg::IRQ_DRDY_BIT] = sample_take;
    irq_events[accel_ctrl_pkg::IRQ_SRST_BIT] = srst_done;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= accel_ctrl_pkg::IRQ_RST;
    end else if (rd_irq) begin
      irq_status_reg <= irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_reg <= accel_ctrl_pkg::IRQ_RST;
    end else if (is_wr(addr, accel_ctrl_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_reg <= wdata;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  //////////////////////////////////////////////////////////////////////////
  // interrupt pins

  accel_ctrl_pkg::pin_cfg_s cfg1;
  accel_ctrl_pkg::pin_cfg_s cfg2;
  accel_ctrl_pkg::irq_pin_s pin1;
  accel_ctrl_pkg::irq_pin_s pin2;
  logic                     pend1;
  logic                     pend2;

  assign cfg1  = pin_cfg(pin1_io_config_reg);
  assign cfg2  = pin_cfg(pin2_io_config_reg);
  assign pend1 = drdy_reg &&
                 drdy_pin_routing_reg[accel_ctrl_pkg::ROUTE_P1_BIT];
  assign pend2 = drdy_reg &&
                 drdy_pin_routing_reg[accel_ctrl_pkg::ROUTE_P2_BIT];

  // open-drain only pulls to the active level; high-active od never drives
  always_comb begin
    pin1.in = irq_pin_one_in;
    pin1.out = (cfg1.output_en && pend1) ? cfg1.polarity
                                         : ~cfg1.polarity;
    pin1.oe = cfg1.output_en &&
              (!cfg1.drive_sel || (pend1 && !cfg1.polarity));
    pin2.in = irq_pin_two_in;
    pin2.out = (cfg2.output_en && pend2) ? cfg2.polarity
                                         : ~cfg2.polarity;
    pin2.oe = cfg2.output_en &&
              (!cfg2.drive_sel || (pend2 && !cfg2.polarity));
  end

  assign irq_pin_one_out = pin1.out;
  assign irq_pin_one_oe  = pin1.oe;
  assign irq_pin_two_out = pin2.out;
  assign irq_pin_two_oe  = pin2.oe;
  assign pin_one_sense   = cfg1.input_en && pin1.in;
  assign pin_two_sense   = cfg2.input_en && pin2.in;

  //////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr)
      accel_ctrl_pkg::ADDR_DRDY_STATUS: begin
        rd_mux[accel_ctrl_pkg::DRDY_BIT] = drdy_reg;
      end
      accel_ctrl_pkg::ADDR_RANGE:      rd_mux = accel_range_sel_reg;
      accel_ctrl_pkg::ADDR_PIN1_CFG:   rd_mux = pin1_io_config_reg;
      accel_ctrl_pkg::ADDR_PIN2_CFG:   rd_mux = pin2_io_config_reg;
      accel_ctrl_pkg::ADDR_ROUTING:    rd_mux = drdy_pin_routing_reg;
      accel_ctrl_pkg::ADDR_SELFTEST:   rd_mux = selftest_control_reg;
      accel_ctrl_pkg::ADDR_PWR_SAVE:   rd_mux = power_save_config_reg;
      accel_ctrl_pkg::ADDR_PWR_EN:     rd_mux = sensor_power_enable_reg;
      accel_ctrl_pkg::ADDR_IRQ_STATUS: rd_mux = irq_status_reg;
      accel_ctrl_pkg::ADDR_IRQ_MASK:   rd_mux = irq_mask_reg;
      default:                         rd_mux = 8'h00;
    endcase
  end

  // write-only soft reset and unmapped addresses read as zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ### accel_regs_chk.sv
`timescale 1ns/1ps
module accel_regs_chk #(
  parameter int          SOFTRESET_CYCLES = 20,
  parameter logic [15:0] SELFTEST_OFFSET  = 16'h0400
) (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        sample_strobe,
  input wire logic [15:0] raw_sample,
  input wire logic        sample_valid,
  input wire logic [15:0] sample_out,
  input wire logic [1:0]  range_code,
  input wire logic        accel_active,
  input wire logic        selftest_on,
  input wire logic        irq_pin_one_in,
  input wire logic        irq_pin_one_oe,
  input wire logic        irq_pin_two_oe,
  input wire logic        pin_one_sense
);
  // window slack of two edges: timer expiry and register update
  localparam int SR_HI = SOFTRESET_CYCLES + 2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  sequence s_accept;
    sample_strobe && accel_active;
  endsequence
  sequence s_key;
    wr_en && addr == 8'h7E && wdata == 8'hB6;
  endsequence
  property p_range;
    wr_en && addr == 8'h41 |=> range_code == $past(wdata[1:0]);
  endproperty
  property p_sample;
    s_accept |=> sample_valid && sample_out == $past(raw_sample)
      + ($past(selftest_on) ? SELFTEST_OFFSET : 16'h0000);
  endproperty
  property p_suspend;
    sample_strobe && !accel_active |=> !sample_valid;
  endproperty
  property p_st_on;
    wr_en && addr == 8'h6D |=> selftest_on == ($past(wdata) == 8'h0D);
  endproperty
  property p_save;
    wr_en && addr == 8'h7C && wdata != 8'h00 |=> !accel_active;
  endproperty
  property p_en;
    wr_en && addr == 8'h7D && wdata != 8'h04 |=> !accel_active;
  endproperty
  property p_oe1;
    wr_en && addr == 8'h53 && !wdata[2] |=> irq_pin_one_oe == $past(wdata[3]);
  endproperty
  property p_oe2;
    wr_en && addr == 8'h54 && !wdata[2] |=> irq_pin_two_oe == $past(wdata[3]);
  endproperty
  property p_sense;
    wr_en && addr == 8'h53 |=>
      pin_one_sense == ($past(wdata[4]) && irq_pin_one_in);
  endproperty
  property p_srst;
    s_key |-> ##[SOFTRESET_CYCLES:SR_HI] (range_code == 2'h1 && !selftest_on);
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_range: assert property (p_range) else $error("range code wrong");
  a_sample: assert property (p_sample) else $error("sample wrong");
  a_suspend: assert property (p_suspend) else $error("sample taken");
  a_st_on: assert property (p_st_on) else $error("self-test wrong");
  a_save: assert property (p_save) else $error("active in save");
  a_en: assert property (p_en) else $error("active while off");
  a_oe1: assert property (p_oe1) else $error("pin one enable");
  a_oe2: assert property (p_oe2) else $error("pin two enable");
  a_sense: assert property (p_sense) else $error("sense wrong");
  a_srst: assert property (p_srst) else $error("soft reset late");
endmodule

// ### pin_board.sv
`timescale 1ns/1ps
module pin_board (
  input  wire logic one_out,
  input  wire logic one_oe,
  input  wire logic two_out,
  input  wire logic two_oe,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      one_wire,
  output logic      two_wire
);
  // pull-up on both lines, so released open-drain pins read high
  assign one_wire = one_oe ? one_out : (ext_en ? ext_val : 1'b1);
  assign two_wire = two_oe ? two_out : (ext_en ? ext_val : 1'b1);
endmodule

// ### tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
      mismatches++; \
      $display("mismatch %s exp %h got %h", nm, ex, gt); \
    end \
  end
module tb;
  localparam int          SR     = 20;
  localparam logic [15:0] ST_OFF = 16'h0400;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        sample_strobe = 1'b0;
  logic [15:0] raw_sample = 16'h0000;
  logic        ext_en = 1'b0;
  logic        ext_val = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] sample_out;
  logic [1:0]  range_code;
  logic        sample_valid, accel_active, selftest_on, irq;
  logic        o1, e1, o2, e2, w1, w2, pin_one_sense, pin_two_sense;
  int          mismatches = 0;
  int          samples_checked = 0;
  accel_control_registers #(.SOFTRESET_CYCLES(SR), .SELFTEST_OFFSET(ST_OFF))
  u_dut (.clock, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .sample_strobe, .raw_sample, .sample_valid, .sample_out, .range_code,
    .accel_active, .selftest_on, .irq_pin_one_in(w1), .irq_pin_one_out(o1),
    .irq_pin_one_oe(e1), .irq_pin_two_in(w2), .irq_pin_two_out(o2),
    .irq_pin_two_oe(e2), .pin_one_sense, .pin_two_sense, .irq);
  pin_board u_board (.one_out(o1), .one_oe(e1), .two_out(o2), .two_oe(e2),
    .ext_en(ext_en), .ext_val(ext_val), .one_wire(w1), .two_wire(w2));
  initial begin
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] ex, string nm);
    @(posedge clock);
    addr <= a; rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    `CHK(nm, ex, rdata)
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge clock);
    raw_sample <= v; sample_strobe <= 1'b1;
    @(posedge clock);
    sample_strobe <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rdc(8'h41, 8'h01, "range");
    rdc(8'h53, 8'h00, "pin1_cfg");
    rdc(8'h54, 8'h00, "pin2_cfg");
    rdc(8'h58, 8'h00, "routing");
    rdc(8'h6D, 8'h00, "selftest");
    rdc(8'h7C, 8'h03, "pwr_save");
    rdc(8'h7D, 8'h00, "pwr_en");
    `CHK("oe1", 1'b0, e1)
  endtask
  task automatic t_masks();
    wr(8'h41, 8'hFF); wr(8'h53, 8'hFF); wr(8'h54, 8'hFF);
    wr(8'h58, 8'hFF); wr(8'h30, 8'hFF);
    rdc(8'h41, 8'h03, "range");
    rdc(8'h53, 8'h1E, "pin1_cfg");
    rdc(8'h54, 8'h1E, "pin2_cfg");
    rdc(8'h58, 8'h44, "routing");
    rdc(8'h30, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(8'h41, 8'(i));
      `CHK("range_code", 2'(i), range_code)
    end
  endtask
  task automatic t_power();
    wr(8'h53, 8'h00); wr(8'h54, 8'h00); wr(8'h58, 8'h00);
    wr(8'h7D, 8'h04);
    smp(16'h1234);
    `CHK("valid", 1'b0, sample_valid)
    rdc(8'h1D, 8'h00, "drdy");
    wr(8'h7C, 8'h00);
    smp(16'h1234);
    `CHK("valid", 1'b1, sample_valid)
    `CHK("sample", 16'h1234, sample_out)
    wr(8'h7D, 8'h05);
    smp(16'h5678);
    `CHK("valid", 1'b0, sample_valid)
    wr(8'h7D, 8'h04);
  endtask
  task automatic t_selftest();
    wr(8'h6D, 8'h0D);
    smp(16'h0100);
    `CHK("sample", 16'h0100 + ST_OFF, sample_out)
    rdc(8'h6D, 8'h0D, "selftest");
    wr(8'h6D, 8'h0C);
    `CHK("st_on", 1'b0, selftest_on)
    wr(8'h6D, 8'h00);
    smp(16'h0100);
    `CHK("sample", 16'h0100, sample_out)
  endtask
  task automatic t_pins();
    wr(8'h58, 8'h44); wr(8'h53, 8'h08); wr(8'h54, 8'h0A); wr(8'h81, 8'h01);
    rdc(8'h1D, 8'h80, "drdy");
    rdc(8'h80, 8'h01, "irq_status");
    `CHK("out1", 1'b1, o1)
    smp(16'h0042);
    `CHK("wire1", 1'b0, w1)
    `CHK("oe2", 1'b1, e2)
    `CHK("out2", 1'b1, o2)
    `CHK("irq", 1'b1, irq)
    rdc(8'h1D, 8'h80, "drdy");
    `CHK("out1", 1'b1, o1)
    `CHK("out2", 1'b0, o2)
    rdc(8'h80, 8'h01, "irq_status");
    `CHK("irq", 1'b0, irq)
    wr(8'h53, 8'h0C);
    `CHK("oe1", 1'b0, e1)
    smp(16'h0043);
    `CHK("oe1", 1'b1, e1)
    `CHK("out1", 1'b0, o1)
    rdc(8'h1D, 8'h80, "drdy");
    wr(8'h58, 8'h40); wr(8'h81, 8'h00);
    smp(16'h0044);
    `CHK("oe1", 1'b0, e1)
    `CHK("out2", 1'b1, o2)
    `CHK("irq", 1'b0, irq)
    rdc(8'h80, 8'h01, "irq_status");
    wr(8'h53, 8'h10); wr(8'h54, 8'h10);
    @(posedge clock);
    ext_en <= 1'b1; ext_val <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("sense1", 1'b1, pin_one_sense)
    `CHK("sense2", 1'b1, pin_two_sense)
    wr(8'h54, 8'h00);
    `CHK("sense2", 1'b0, pin_two_sense)
    @(posedge clock);
    ext_en <= 1'b0;
  endtask
  task automatic t_softreset();
    wr(8'h41, 8'h03); wr(8'h6D, 8'h0D);
    wr(8'h7E, 8'hB6);
    repeat (SR / 2) @(posedge clock);
    #1;
    `CHK("range_code", 2'h3, range_code)
    repeat (SR) @(posedge clock);
    #1;
    `CHK("range_code", 2'h1, range_code)
    `CHK("st_on", 1'b0, selftest_on)
    `CHK("active", 1'b0, accel_active)
    rdc(8'h58, 8'h00, "routing");
    rdc(8'h80, 8'h02, "irq_status");
    rdc(8'h1D, 8'h00, "drdy");
    wr(8'h7C, 8'h00); wr(8'h7D, 8'h04);
    smp(16'h0007);
    `CHK("valid", 1'b1, sample_valid)
    // status read and new sample on one edge: the set must win
    @(posedge clock);
    addr <= 8'h1D; rd_en <= 1'b1; sample_strobe <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0; sample_strobe <= 1'b0;
    #1;
    `CHK("drdy", 8'h80, rdata)
    rdc(8'h1D, 8'h80, "drdy");
    rdc(8'h1D, 8'h00, "drdy");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // run is about two hundred cycles; limit leaves wide margin
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_defaults();
    t_masks();
    t_power();
    t_selftest();
    t_pins();
    t_softreset();
    report_and_stop();
  end
endmodule
bind accel_control_registers accel_regs_chk #(
  .SOFTRESET_CYCLES(SOFTRESET_CYCLES), .SELFTEST_OFFSET(SELFTEST_OFFSET)
) u_chk (.clock, .reset_n, .addr, .wdata, .wr_en, .sample_strobe,
  .raw_sample, .sample_valid, .sample_out, .range_code, .accel_active,
  .selftest_on, .irq_pin_one_in, .irq_pin_one_oe, .irq_pin_two_oe,
  .pin_one_sense);
